// ===== design/vit_pkg.sv
// Notes on behaviour
// RULE_01: Traceback starts at best-metric final state.
// RULE_02: Zero-terminated blocks carry K-1 zero tail bits.
// RULE_03: Sub-block holds one word per state.
// RULE_04: Sub-block saved every 16-(K-1) stages.
// RULE_05: Leading K-1 bits index previous word.
// RULE_06: Copy trailing 16-(K-1) bits to output.
// RULE_07: Step back per sub-block, stop after 0.
// RULE_08: Twelve bits per sub-block, continuous stream.
// RULE_09: Sixteen 40-bit registers, halves plus extension.
// RULE_10: Four ALU ops plus two transfers per cycle.
// RULE_11: Dual add on both 16-bit halves.
// RULE_12: Dual subtract on both 16-bit halves.
// RULE_13: No carry across bit 15; extension undefined.
// RULE_14: Low half max-select sets low flag.
// RULE_15: High half max-select sets high flag.
// RULE_16: Signs from bits 15 and 31; extension follows high.
// RULE_17: Decision flags live in core status word.
// RULE_18: High-bank max-select needs encoding prefix.
// RULE_19: Flag tells origin state j or j+S/2.
// RULE_20: Survivor update shifts left, inserts origin bit.
// RULE_21: Each survivor path is one 16-bit half.
// RULE_22: Fixed-zero final state starts at word zero.
// RULE_23: Max-select updates halves and flags together.
package vit_pkg;

   // ****************************************
   // Geometry and opcodes
   // ****************************************
   localparam int NUM_REGS    = 16;
   localparam int NUM_LANES   = 4;
   localparam int HALF_W      = 16;
   localparam int CONSTRAINT_K = 5;
   localparam int PTR_W       = CONSTRAINT_K - 1;
   localparam int DATA_BITS   = HALF_W - PTR_W;
   localparam int NUM_STATES  = 1 << PTR_W;
   localparam int FIFO_DEPTH  = 8;
   localparam logic [1:0] FLAG_RESET = 2'h0;

   typedef enum logic [1:0] {
      op_nop            = 2'h0,
      op_dual_half_add  = 2'h1,
      op_dual_half_sub  = 2'h2,
      op_dual_max_select = 2'h3
   } alu_op_e;

   typedef enum logic [1:0] {
      tb_idle  = 2'b00,
      tb_fetch = 2'b01,
      tb_emit  = 2'b11
   } tb_state_e;

   typedef struct packed {
      logic [7:0]  ext;
      logic [15:0] hi;
      logic [15:0] lo;
   } data_reg_s;

   typedef struct packed {
      alu_op_e    op;
      logic [3:0] src;
      logic [3:0] dst;
   } alu_cmd_s;

   typedef struct packed {
      logic [1:0]  slot;
      logic        valid;
      logic [3:0]  dst;
      logic [39:0] data;
   } xfer_s;

endpackage

// ===== design/viterbi_acs_traceback_datapath.sv
`timescale 1ns/10ps

// ****************************************
// Output stream FIFO
// ****************************************
module stream_fifo import vit_pkg::*; #(
   parameter int WIDTH = DATA_BITS,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 count;
   } fifo_s;

   fifo_s cur;
   fifo_s next_cur;
   logic  push;
   logic  pop;

   assign in_ready  = (cur.count != (AW+1)'(DEPTH));
   assign out_valid = (cur.count != '0);
   assign out_data  = cur.mem[cur.rd];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      next_cur = cur;
      if (push) begin
         next_cur.mem[cur.wr] = in_data;
         next_cur.wr = (cur.wr == AW'(DEPTH-1)) ? '0 : cur.wr + 1'b1;
      end
      if (pop) begin
         next_cur.rd = (cur.rd == AW'(DEPTH-1)) ? '0 : cur.rd + 1'b1;
      end
      next_cur.count = cur.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end
endmodule

// ****************************************
// Datapath with traceback
// ****************************************
module viterbi_acs_traceback_datapath import vit_pkg::*; #(
   parameter int LANES  = NUM_LANES,
   parameter int SUB_W  = 8
) (
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   input  wire alu_cmd_s [LANES-1:0]        alu_cmd,
   input  wire xfer_s    [1:0]              xfer_in,
   input  wire logic     [3:0]              rd_sel,
   output data_reg_s                        rd_data,
   output logic          [1:0]              decision_flags,
   input  wire logic                        tb_start,
   input  wire logic                        tb_zero_final,
   input  wire logic     [PTR_W-1:0]        tb_best_state,
   input  wire logic     [SUB_W-1:0]        tb_last_sub,
   output logic                             tb_busy,
   output logic          [SUB_W-1:0]        mem_sub,
   output logic          [PTR_W-1:0]        mem_word,
   output logic                             mem_req,
   input  wire logic     [HALF_W-1:0]       mem_rdata,
   output logic                             bit_valid,
   input  wire logic                        bit_ready,
   output logic          [DATA_BITS-1:0]    bit_data
);
   typedef struct packed {
      data_reg_s [NUM_REGS-1:0] regs;
      logic [1:0]               flags;
      tb_state_e                tb;
      logic [SUB_W-1:0]         sub;
      logic [PTR_W-1:0]         word;
      logic [DATA_BITS-1:0]     chunk;
   } dp_s;

   dp_s  cur;
   dp_s  next_cur;
   logic fifo_ready;

   // Max-select compares each whole 16-bit half as a signed value
   function automatic logic src_wins(input logic [15:0] s, input logic [15:0] d);
      src_wins = $signed(s) > $signed(d); // RULE_16
   endfunction

   always_comb begin
      next_cur = cur;
      // Four lanes per cycle; later lanes win a shared destination
      for (int i = 0; i < LANES; i++) begin // RULE_10
         data_reg_s s;
         data_reg_s d;
         s = cur.regs[alu_cmd[i].src];
         d = cur.regs[alu_cmd[i].dst];
         unique case (alu_cmd[i].op)
            op_dual_half_add: begin
               d.lo = s.lo + d.lo; // RULE_11 RULE_13
               d.hi = s.hi + d.hi; // RULE_11 RULE_13
               d.ext = '0;
            end
            op_dual_half_sub: begin
               d.lo = d.lo - s.lo; // RULE_12 RULE_13
               d.hi = d.hi - s.hi; // RULE_12 RULE_13
               d.ext = '0;
            end
            op_dual_max_select: begin
               // Both halves and both flags in one cycle
               if (src_wins(s.lo, d.lo)) begin // RULE_14 RULE_23
                  d.lo = s.lo;
                  next_cur.flags[0] = 1'b0;
               end else begin
                  next_cur.flags[0] = 1'b1; // RULE_19
               end
               if (src_wins(s.hi, d.hi)) begin // RULE_15 RULE_23
                  d.hi = s.hi;
                  d.ext = s.ext; // RULE_16
                  next_cur.flags[1] = 1'b0;
               end else begin
                  next_cur.flags[1] = 1'b1; // RULE_19
               end
            end
            default: begin
            end
         endcase
         if (alu_cmd[i].op != op_nop) begin
            next_cur.regs[alu_cmd[i].dst] = d; // RULE_09 RULE_21
         end
      end
      // Two address-unit load transfers per cycle
      for (int j = 0; j < 2; j++) begin // RULE_10
         if (xfer_in[j].valid) begin
            next_cur.regs[xfer_in[j].dst] = xfer_in[j].data;
         end
      end

      // Traceback: copy data bits, follow pointer back one sub-block
      unique case (cur.tb)
         tb_idle: begin
            if (tb_start) begin
               next_cur.sub  = tb_last_sub;
               next_cur.word = tb_zero_final ? '0 : tb_best_state; // RULE_01 RULE_22
               next_cur.tb   = tb_fetch;
            end
         end
         tb_fetch: begin
            // Word index n of a sub-block is the state n
            next_cur.chunk = mem_rdata[DATA_BITS-1:0]; // RULE_03 RULE_05 RULE_06
            next_cur.word  = mem_rdata[HALF_W-1:DATA_BITS]; // RULE_04 RULE_05
            next_cur.tb    = tb_emit;
         end
         tb_emit: begin
            if (fifo_ready) begin // RULE_08
               if (cur.sub == '0) begin
                  next_cur.tb = tb_idle; // RULE_07
               end else begin
                  next_cur.sub = cur.sub - 1'b1; // RULE_07
                  next_cur.tb  = tb_fetch;
               end
            end
         end
         default: begin
            next_cur.tb = tb_idle;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign rd_data        = cur.regs[rd_sel];
   assign decision_flags = cur.flags; // RULE_17
   assign tb_busy        = (cur.tb != tb_idle);
   assign mem_req        = (cur.tb == tb_fetch);
   assign mem_sub        = cur.sub;
   assign mem_word       = cur.word;

   stream_fifo #(
      .WIDTH (DATA_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (cur.tb == tb_emit),
      .in_ready  (fifo_ready),
      .in_data   (cur.chunk),
      .out_valid (bit_valid),
      .out_ready (bit_ready),
      .out_data  (bit_data)
   );
endmodule

// ===== test/surv_mem.sv
`timescale 1ns/10ps
// ********
// Survivor memory
// ********
module surv_mem import vit_pkg::*; (
   input  wire logic              mem_req,
   input  wire logic [7:0]        mem_sub,
   input  wire logic [PTR_W-1:0]  mem_word,
   output logic      [HALF_W-1:0] mem_rdata
);
   function automatic logic [15:0] word_at(logic [7:0] s, logic [3:0] w);
      return {4'(s * 3 + w * 5 + 1), 12'(s * 165 + w * 317)};
   endfunction
   // Word stands only while requested, scrambled otherwise
   assign mem_rdata = mem_req ? word_at(mem_sub, mem_word) : ~word_at(mem_sub, mem_word);
endmodule

// ===== test/vit_dp_props.sv
`timescale 1ns/10ps
// ********
// Checker
// ********
module vit_dp_props import vit_pkg::*; #(
   parameter int LANES = NUM_LANES,
   parameter int SUB_W = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire alu_cmd_s [LANES-1:0] alu_cmd,
   input wire xfer_s [1:0] xfer_in,
   input wire logic [3:0] rd_sel,
   input wire data_reg_s rd_data,
   input wire logic [1:0] decision_flags,
   input wire logic tb_start,
   input wire logic tb_zero_final,
   input wire logic [PTR_W-1:0] tb_best_state,
   input wire logic [SUB_W-1:0] tb_last_sub,
   input wire logic tb_busy,
   input wire logic [SUB_W-1:0] mem_sub,
   input wire logic [PTR_W-1:0] mem_word,
   input wire logic mem_req,
   input wire logic [HALF_W-1:0] mem_rdata,
   input wire logic bit_valid,
   input wire logic bit_ready,
   input wire logic [DATA_BITS-1:0] bit_data
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   alu_cmd_s         lc;
   logic             go, same;
   logic [PTR_W-1:0] ptr_q;
   logic [SUB_W-1:0] sub_q;
   assign lc = alu_cmd[LANES-1];
   assign go = tb_start && !tb_busy;
   assign same = lc.src == lc.dst && lc.dst == rd_sel && !xfer_in[0].valid && !xfer_in[1].valid;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= '0;
         sub_q <= '0;
      end else if (mem_req) begin
         ptr_q <= mem_rdata[HALF_W-1-:PTR_W];
         sub_q <= mem_sub;
      end
   end
   start_word_a: assert property (go && !tb_zero_final |=> mem_word == $past(tb_best_state))
      else $error("bad start word");
   zero_word_a: assert property (go && tb_zero_final |=> mem_word == '0)
      else $error("bad zero start");
   start_sub_a: assert property (go |=> mem_req && mem_sub == $past(tb_last_sub))
      else $error("bad start sub");
   ptr_follow_a: assert property (mem_req && !$past(go) |-> mem_word == ptr_q && mem_sub == sub_q - 1'b1)
      else $error("bad pointer step");
   stop_zero_a: assert property (mem_req && mem_sub == '0 |=> !mem_req [*2])
      else $error("fetch after sub zero");
   add_self_a: assert property ((lc.op == op_dual_half_add && same ##1 $stable(rd_sel)) |->
      rd_data.lo == {$past(rd_data.lo[14:0]), 1'b0} && rd_data.hi == {$past(rd_data.hi[14:0]), 1'b0})
      else $error("bad dual add");
   sub_self_a: assert property ((lc.op == op_dual_half_sub && same ##1 $stable(rd_sel)) |->
      rd_data.hi == '0 && rd_data.lo == '0) else $error("bad dual sub");
   max_self_a: assert property ((lc.op == op_dual_max_select && same ##1 $stable(rd_sel)) |->
      decision_flags == 2'h3 && rd_data == $past(rd_data)) else $error("bad max select");
   stream_hold_a: assert property (bit_valid && !bit_ready |=> bit_valid && $stable(bit_data))
      else $error("stream dropped");
endmodule
bind viterbi_acs_traceback_datapath vit_dp_props #(.LANES(LANES), .SUB_W(SUB_W)) props (
   .clock          (clock),
   .rst_n          (rst_n),
   .alu_cmd        (alu_cmd),
   .xfer_in        (xfer_in),
   .rd_sel         (rd_sel),
   .rd_data        (rd_data),
   .decision_flags (decision_flags),
   .tb_start       (tb_start),
   .tb_zero_final  (tb_zero_final),
   .tb_best_state  (tb_best_state),
   .tb_last_sub    (tb_last_sub),
   .tb_busy        (tb_busy),
   .mem_sub        (mem_sub),
   .mem_word       (mem_word),
   .mem_req        (mem_req),
   .mem_rdata      (mem_rdata),
   .bit_valid      (bit_valid),
   .bit_ready      (bit_ready),
   .bit_data       (bit_data)
);

// ===== test/viterbi_acs_traceback_datapath_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module viterbi_acs_traceback_datapath_tb import vit_pkg::*;;
   logic           clock = 0, rst_n = 0, tb_start = 0, tb_zero_final = 0, bit_ready = 0, hold = 1;
   alu_cmd_s [3:0] alu_cmd = '0;
   xfer_s [1:0]    xfer_in = '0;
   logic [3:0]     rd_sel = '0, tb_best_state = '0, mem_word, sr, dr, w;
   logic [7:0]     tb_last_sub = '0, mem_sub;
   logic [1:0]     decision_flags;
   logic           tb_busy, mem_req, bit_valid;
   logic [15:0]    mem_rdata, m;
   logic [11:0]    bit_data, q[$];
   data_reg_s      rd_data, s, d;
   logic [41:0]    e;
   alu_op_e        op;
   int             fails = 0, n_tests = 0, ls;
   always #4 clock = ~clock;
   viterbi_acs_traceback_datapath DUT (.clock, .rst_n, .alu_cmd, .xfer_in, .rd_sel, .rd_data, .decision_flags,
      .tb_start, .tb_zero_final, .tb_best_state, .tb_last_sub, .tb_busy, .mem_sub, .mem_word, .mem_req,
      .mem_rdata, .bit_valid, .bit_ready, .bit_data);
   surv_mem mem (.mem_req, .mem_sub, .mem_word, .mem_rdata);
   function automatic logic [41:0] model(alu_op_e o, data_reg_s a, data_reg_s b);
      logic f1, f0;
      f0 = $signed(a.lo) <= $signed(b.lo);
      f1 = $signed(a.hi) <= $signed(b.hi);
      if (o == op_dual_half_add) return {2'h0, b.ext, a.hi + b.hi, a.lo + b.lo};
      if (o == op_dual_half_sub) return {2'h0, b.ext, b.hi - a.hi, b.lo - a.lo};
      return {f1, f0, f1 ? b.ext : a.ext, f1 ? b.hi : a.hi, f0 ? b.lo : a.lo};
   endfunction
   task automatic tick(int n = 1);
      repeat (n) @(posedge clock);
   endtask
   task automatic test_done;
      if (fails == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clock) bit_ready <= !hold && $urandom % 4 != 0;
   always @(negedge clock) if (bit_valid && bit_ready) begin
      `CHK("bits", q[0], bit_data)
      void'(q.pop_front());
   end
   initial begin
      void'($urandom(32'h98ea_b052));
      tick(4);
      rst_n <= 1;
      for (int i = 0; i < 48; i++) begin
         tick;
         s = i < 2 ? 40'hff_7fff_8000 : 40'({$urandom, $urandom});
         d = i < 2 ? 40'h00_8000_7fff : 40'({$urandom, $urandom});
         op = alu_op_e'(3 - (i / 4) % 3);
         sr = 4'(i);
         dr = i % 4 == 3 ? sr : 4'(i + 7);
         if (sr == dr) d = s;
         xfer_in <= {2'h0, 1'b1, dr, d, 2'h0, sr != dr, sr, s};
         rd_sel <= dr;
         tick;
         xfer_in <= '0;
         alu_cmd[i % 4] <= {op, sr, dr};
         #1 `CHK("reg", d, rd_data)
         tick;
         alu_cmd <= '0;
         e = model(op, s, d);
         #1 if (op == op_dual_max_select) `CHK("max", e, {decision_flags, rd_data})
         else `CHK("addsub", e[31:0], rd_data[31:0])
      end
      for (int t = 0; t < 3; t++) begin
         tick;
         w = 4'($urandom);
         ls = t == 0 ? 9 : t * 3 - 3;
         tb_best_state <= w;
         tb_zero_final <= t == 0;
         tb_last_sub <= 8'(ls);
         hold <= t == 0;
         if (t == 0) w = 4'h0;
         for (int k = ls; k >= 0; k--) begin
            m = mem.word_at(8'(k), w);
            q.push_back(m[11:0]);
            w = m[15:12];
         end
         tb_start <= 1;
         tick;
         tb_start <= 0;
         tick(3);
         tb_start <= t == 0;
         tick;
         tb_start <= 0;
         tick(30);
         hold <= 0;
         for (int k = 0; k < 400 && (tb_busy || q.size() > 0); k++) begin
            tick;
            #1;
         end
         `CHK("drain", 33'h0, {tb_busy, 32'(q.size())})
      end
      test_done;
   end
endmodule
